// ### verif/tb_tmr_tape_word_codec.sv
`default_nettype none
module tb_tmr_tape_word_codec;
    timeunit 1ns;
    timeprecision 1ns;
    import tmc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd_restart = 1'b0;
    logic slow = 1'b0;
    logic wr_ready, wr_tape_ready, parity_fail;
    tmc_word_type wr_word = '0;
    tmc_word_type rd_word;
    tmc_tape_type wr_tape, rd_tape;
    int errors = 0;
    int n_compared = 0;
    int n_words = 0;
    logic [14:0] got_word;
    logic [53:0] t;
    always #50 clk = ~clk;
    tmc_codec uut (.clk(clk), .rst_n(rst_n), .wr_word(wr_word),
        .wr_ready(wr_ready), .wr_tape(wr_tape),
        .wr_tape_ready(wr_tape_ready), .rd_tape(rd_tape),
        .rd_restart(rd_restart), .rd_word(rd_word),
        .parity_fail(parity_fail));
    tmc_tape_model tape (.clk(clk), .wr_tape(wr_tape),
        .wr_tape_ready(wr_tape_ready), .slow(slow), .rd_tape(rd_tape));
    always @(negedge clk) begin
        if (rd_word.valid === 1'b1) begin
            n_words <= n_words + 1;
            got_word <= rd_word.bits;
        end
    end
    // ********
    // helpers
    // ********
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [17:0] tw(input logic [14:0] w, input int i);
        logic [5:0] g;
        g = {~^w[i*5 +: 5], w[i*5 +: 5]};
        return {g, ~g, g};
    endfunction
    function automatic logic [53:0] clean(input logic [14:0] w);
        return {tw(w, 2), tw(w, 1), tw(w, 0)};
    endfunction
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic write_word(input logic [14:0] w);
        int n;
        int k;
        n = tape.got.size();
        k = 0;
        wr_word <= '{1'b1, w};
        while (wr_ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        wr_word <= '{1'b0, ~w};
        check({17'h0, wr_ready}, 18'h0);
        while (tape.got.size() < n + 3 && k < 200) begin
            @(negedge clk);
            k++;
        end
        check(18'(tape.got.size() - n), 18'h3);
        for (int i = 0; i < 3; i++) begin
            check(tape.got[n + i], tw(w, i));
        end
    endtask
    task automatic read_word(input logic [14:0] w, input logic fail);
        int n;
        n = n_words;
        for (int i = 0; i < 3; i++) begin
            tape.send(t[i*18 +: 18]);
        end
        check(18'(n_words - n), {17'h0, !fail});
        if (!fail) begin
            check({3'h0, got_word}, {3'h0, w});
        end
        check({17'h0, parity_fail}, {17'h0, fail});
    endtask
    // ********
    // scenarios
    // ********
    task automatic s_write;
        write_word(15'h0000);
        write_word(15'h7fff);
        slow <= 1'b1;
        write_word(15'h2b5c);
        slow <= 1'b0;
    endtask
    // two-copy errors force the correction; one-copy error is outvoted
    task automatic s_read_fix;
        t = clean(15'h1234);
        read_word(15'h1234, 1'b0);
        t = clean(15'h6a59);
        t[0] = ~t[0];
        t[6] = ~t[6];
        t[29] = ~t[29];
        t[35] = ~t[35];
        t[51] = ~t[51];
        read_word(15'h6a59, 1'b0);
    endtask
    // a unanimous wrong bit cannot be corrected
    task automatic s_read_fail;
        t = clean(15'h0f0f);
        t[19] = ~t[19];
        t[25] = ~t[25];
        t[31] = ~t[31];
        read_word(15'h0f0f, 1'b1);
        rd_restart <= 1'b1;
        @(negedge clk);
        rd_restart <= 1'b0;
        @(negedge clk);
        t = clean(15'h4321);
        read_word(15'h4321, 1'b0);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        s_write();
        s_read_fix();
        s_read_fail();
        report_and_stop();
    end
    // reads need about 10k cycles of 100 ns
    initial begin
        #4_000_000;
        errors++;
        report_and_stop();
    end
endmodule // tb_tmr_tape_word_codec
`default_nettype wire

// ### verif/tmc_tape_model.sv
`default_nettype none
module tmc_tape_model #(
    parameter int GAP = tmc_pkg::TAPE_PERIOD_CYC
) (
    // clock
    input wire logic clk,
    // write channel
    input wire tmc_pkg::tmc_tape_type wr_tape,
    output logic wr_tape_ready,
    input wire logic slow,
    // read channel
    output tmc_pkg::tmc_tape_type rd_tape
);
    timeunit 1ns;
    timeprecision 1ns;
    import tmc_pkg::*;
    logic [17:0] got[$];
    logic [1:0] phase = 2'h0;
    initial begin
        rd_tape = '0;
        wr_tape_ready = 1'b0;
    end
    // ********
    // write channel: slow mode stalls three cycles in four
    // ********
    always @(negedge clk) begin
        phase <= phase + 2'h1;
        wr_tape_ready <= !slow || phase == 2'h3;
    end
    always @(posedge clk) begin
        if (wr_tape.valid && wr_tape_ready) begin
            got.push_back(wr_tape.bits);
        end
    end
    // ********
    // read channel: one strobe, then the gap between tape words
    // ********
    // idle bits show the inverse so stale data never looks valid
    task automatic send(input logic [17:0] b);
        rd_tape <= '{1'b1, b};
        @(negedge clk);
        rd_tape <= '{1'b0, ~b};
        repeat (GAP - 1) @(negedge clk);
    endtask
endmodule // tmc_tape_model
`default_nettype wire

// ### verilog/tmc_codec.sv
`default_nettype none
// How it works
// RQ1 - encoder splits each 15-bit word into three 5-bit groups
// RQ2 - each group gets an odd parity bit over six bits
// RQ3 - tape word holds group true, inverted, true across 18 tracks
// RQ4 - tape words go out first group first, then second, third
// RQ5 - received tape word, already deskewed, is strobed into a buffer
// RQ6 - tracks n, n+6, n+12 are the three copies of group bit n
// RQ7 - centre copy re-inverted, six bits majority voted into register
// RQ8 - on parity failure toggle the bit whose voter disagreed
// RQ9 - recheck parity; accepted group lands in its third, parity kept
// RQ10 - after three groups, composite parity checks all fifteen bits
// RQ11 - good word goes to core memory before next tape word
// RQ12 - tape words arrive about every 78 us; decode finishes well within
// RQ13 - uncorrectable group or bad composite rejects word, raises flag
module tmc_codec (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write path: core memory word to tape
    input wire tmc_pkg::tmc_word_type wr_word,
    output logic wr_ready,
    output tmc_pkg::tmc_tape_type wr_tape,
    input wire logic wr_tape_ready,
    // read path: deskewed tape word to core memory
    input wire tmc_pkg::tmc_tape_type rd_tape,
    input wire logic rd_restart,
    output tmc_pkg::tmc_word_type rd_word,
    output logic parity_fail
);
    import tmc_pkg::*;

    // ********************************************************
    // write path
    // ********************************************************
    tmc_encoder u_enc (
        .clk(clk),
        .rst_n(rst_n),
        .word_in(wr_word),
        .word_ready(wr_ready),
        .tape_out(wr_tape),
        .tape_ready(wr_tape_ready)
    );

    // ********************************************************
    // read path
    // ********************************************************
    tmc_dec_state_type state;
    logic [17:0] in_buf;
    logic [5:0] voted_group_register;
    logic [5:0] next_voted;
    logic [5:0] disagree;
    logic [14:0] assembly;
    logic [2:0] held_par;
    logic [1:0] grp;
    logic bad_seen;
    logic grp_ok;

    // per bit: copies, centre uninverted, vote and disagreement
    genvar gi;
    generate
        for (gi = 0; gi < GRP_BITS; gi++) begin : g_vote
            logic ca, cb, cc;
            assign ca = in_buf[COPY_A + gi]; // see RQ6
            assign cb = ~in_buf[COPY_B + gi]; // see RQ7
            assign cc = in_buf[COPY_C + gi];
            assign next_voted[gi] = (ca & cb) | (ca & cc) | (cb & cc);
            assign disagree[gi] = !((ca == cb) && (cb == cc));
        end
    endgenerate

    assign grp_ok = ^voted_group_register;

    // buffer strobe; only taken when idle, words come far apart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_buf <= TAPE_RST;
        end else if (state == DEC_IDLE && rd_tape.valid) begin
            in_buf <= rd_tape.bits; // see RQ5
        end
    end

    // four cycles per tape word, far below the tape period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DEC_IDLE;
        end else begin
            unique case (state)
                DEC_IDLE: begin
                    if (rd_tape.valid) begin
                        state <= DEC_VOTE;
                    end
                end
                DEC_VOTE: state <= DEC_FIX;
                DEC_FIX: state <= DEC_CHECK;
                DEC_CHECK: state <= DEC_IDLE; // see RQ12
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            voted_group_register <= 6'h00;
        end else if (state == DEC_VOTE) begin
            voted_group_register <= next_voted; // see RQ7
        end else if (state == DEC_FIX && !grp_ok) begin
            // a triple error may show two disagreeing voters; both flip
            voted_group_register <= voted_group_register ^ disagree; // see RQ8
        end
    end

    // group accumulation and word release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            assembly <= WORD_RST;
            held_par <= 3'h0;
            grp <= GRP_CNT_RST;
            bad_seen <= 1'b0;
            rd_word <= '0;
            parity_fail <= 1'b0;
        end else begin
            rd_word.valid <= 1'b0;
            // a clear and a new failure in one cycle: the failure wins
            if (rd_restart) begin
                parity_fail <= 1'b0;
            end
            if (state == DEC_CHECK) begin
                if (grp_ok) begin
                    assembly[5*grp +: 5] <= voted_group_register[4:0]; // see RQ9
                    held_par[grp] <= voted_group_register[5];
                end
                if (grp == GRP_LAST) begin
                    grp <= GRP_CNT_RST;
                    bad_seen <= 1'b0;
                    // composite: odd groups sum to odd total of 18 bits
                    if (grp_ok && !bad_seen &&
                        (^{assembly[9:0], voted_group_register,
                           held_par[1:0]})) begin // see RQ10
                        rd_word.valid <= 1'b1; // see RQ11
                        rd_word.bits <= {voted_group_register[4:0],
                                         assembly[9:0]};
                    end else begin
                        parity_fail <= 1'b1; // see RQ13
                    end
                end else begin
                    grp <= grp + 2'h1;
                    bad_seen <= bad_seen | !grp_ok; // see RQ13
                end
            end
            if (rd_restart) begin
                grp <= GRP_CNT_RST;
                bad_seen <= 1'b0;
            end
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    property p_fix_parity;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_FIX && !grp_ok && $countones(disagree) == 1)
            |=> grp_ok;
    endproperty
    a_fix_parity: assert property (p_fix_parity) // see RQ8
        else $error("single disagreement not corrected");

    property p_decode_time;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_IDLE && rd_tape.valid) |=> ##2 state == DEC_CHECK
            ##1 state == DEC_IDLE;
    endproperty
    a_decode_time: assert property (p_decode_time) // see RQ12
        else $error("decode sequence length wrong");

    property p_out_pulse;
        @(posedge clk) disable iff (!rst_n)
        rd_word.valid |=> !rd_word.valid;
    endproperty
    a_out_pulse: assert property (p_out_pulse) // see RQ11
        else $error("word valid longer than one cycle");

    property p_out_parity;
        @(posedge clk) disable iff (!rst_n)
        $rose(rd_word.valid) |-> $past(state) == DEC_CHECK;
    endproperty
    a_out_parity: assert property (p_out_parity) // see RQ10
        else $error("word released outside check");

    property p_no_both;
        @(posedge clk) disable iff (!rst_n)
        rd_word.valid |-> !$rose(parity_fail);
    endproperty
    a_no_both: assert property (p_no_both) // see RQ13
        else $error("word released and rejected together");

    property p_vote_load;
        @(posedge clk) disable iff (!rst_n)
        state == DEC_VOTE |=> voted_group_register == $past(next_voted);
    endproperty
    a_vote_load: assert property (p_vote_load) // see RQ7
        else $error("voted group not loaded");

    property p_enc_parity;
        @(posedge clk) disable iff (!rst_n)
        wr_tape.valid |-> ^wr_tape.bits[5:0];
    endproperty
    a_enc_parity: assert property (p_enc_parity) // see RQ2
        else $error("encoded group not odd parity");

    property p_enc_copies;
        @(posedge clk) disable iff (!rst_n)
        wr_tape.valid |-> (wr_tape.bits[17:12] == ~wr_tape.bits[11:6])
            && (wr_tape.bits[17:12] == wr_tape.bits[5:0]);
    endproperty
    a_enc_copies: assert property (p_enc_copies) // see RQ3
        else $error("tape copies inconsistent");

    property p_buf_load;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_IDLE && rd_tape.valid)
            |=> in_buf == $past(rd_tape.bits);
    endproperty
    a_buf_load: assert property (p_buf_load) // see RQ5
        else $error("tape word not strobed into buffer");

    property p_buf_hold;
        @(posedge clk) disable iff (!rst_n)
        state != DEC_IDLE |=> $stable(in_buf);
    endproperty
    a_buf_hold: assert property (p_buf_hold) // see RQ5
        else $error("buffer changed while decoding");

    property p_vote_true;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_VOTE && disagree == 6'h00)
            |=> voted_group_register == $past(in_buf[5:0]);
    endproperty
    a_vote_true: assert property (p_vote_true) // see RQ6
        else $error("unanimous vote differs from first copy");

    property p_vote_centre;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_VOTE && disagree == 6'h00)
            |=> voted_group_register == ~$past(in_buf[11:6]);
    endproperty
    a_vote_centre: assert property (p_vote_centre) // see RQ7
        else $error("centre copy not re-inverted");

    property p_fix_keep;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_FIX && grp_ok) |=> $stable(voted_group_register);
    endproperty
    a_fix_keep: assert property (p_fix_keep) // see RQ8
        else $error("good group altered by correction");

    property p_accept;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_CHECK && grp_ok && grp == GRP_CNT_RST)
            |=> assembly[4:0] == $past(voted_group_register[4:0])
            && held_par[0] == $past(voted_group_register[5]);
    endproperty
    a_accept: assert property (p_accept) // see RQ9
        else $error("accepted group not stored");

    property p_release_last;
        @(posedge clk) disable iff (!rst_n)
        rd_word.valid |-> $past(grp) == GRP_LAST;
    endproperty
    a_release_last: assert property (p_release_last) // see RQ10
        else $error("word released before third group");

    property p_fail_set;
        @(posedge clk) disable iff (!rst_n)
        (state == DEC_CHECK && !grp_ok && grp == GRP_LAST) |=> parity_fail;
    endproperty
    a_fail_set: assert property (p_fail_set) // see RQ13
        else $error("bad last group not flagged");

    property p_fail_sticky;
        @(posedge clk) disable iff (!rst_n)
        (parity_fail && !rd_restart) |=> parity_fail;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky) // see RQ13
        else $error("failure flag dropped without restart");

    property p_fail_clear;
        @(posedge clk) disable iff (!rst_n)
        (rd_restart && state != DEC_CHECK) |=> !parity_fail;
    endproperty
    a_fail_clear: assert property (p_fail_clear) // see RQ13
        else $error("failure flag not cleared by restart");

    property p_enc_hold;
        @(posedge clk) disable iff (!rst_n)
        (wr_tape.valid && !wr_tape_ready) |=> $stable(wr_tape);
    endproperty
    a_enc_hold: assert property (p_enc_hold) // see RQ4
        else $error("tape word changed before it was taken");

    property p_enc_busy;
        @(posedge clk) disable iff (!rst_n)
        (wr_word.valid && wr_ready) |=> !wr_ready;
    endproperty
    a_enc_busy: assert property (p_enc_busy) // see RQ4
        else $error("encoder ready while groups pending");

endmodule : tmc_codec
`default_nettype wire

// ### verilog/tmc_encoder.sv
`default_nettype none
module tmc_encoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // computer word in
    input wire tmc_pkg::tmc_word_type word_in,
    output logic word_ready,
    // tape word out
    output tmc_pkg::tmc_tape_type tape_out,
    input wire logic tape_ready
);
    import tmc_pkg::*;
    logic [14:0] held;
    logic [1:0] grp;
    logic busy;
    logic [4:0] sel;
    logic [5:0] grp6;
    // first group is the low five bits, consumed first
    always_comb begin
        sel = held[5*grp +: 5]; // see RQ1 see RQ4
        grp6 = {~^sel, sel}; // see RQ2
    end
    assign word_ready = !busy;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            held <= WORD_RST;
            grp <= GRP_CNT_RST;
        end else if (!busy) begin
            if (word_in.valid) begin
                busy <= 1'b1;
                held <= word_in.bits;
                grp <= GRP_CNT_RST;
            end
        end else if (!tape_out.valid || tape_ready) begin
            // step only when the output stage loads, so a stall never skips a group
            if (grp == GRP_LAST) begin
                busy <= 1'b0;
                grp <= GRP_CNT_RST;
            end else begin
                grp <= grp + 2'h1; // see RQ4
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tape_out <= '0;
        end else begin
            // output stage holds a word until the channel takes it
            if (busy && (!tape_out.valid || tape_ready)) begin
                tape_out.valid <= 1'b1;
                tape_out.bits <= {grp6, ~grp6, grp6}; // see RQ3
            end else if (tape_ready) begin
                tape_out.valid <= 1'b0;
            end
        end
    end
endmodule : tmc_encoder
`default_nettype wire

// ### verilog/tmc_pkg.sv
`default_nettype none
package tmc_pkg;
    // ********************************************************
    // widths
    // ********************************************************
    localparam int unsigned WORD_BITS = 15;
    localparam int unsigned GRP_DATA = 5;
    localparam int unsigned GRP_BITS = 6;
    localparam int unsigned TAPE_BITS = 18;
    localparam int unsigned NUM_GRPS = 3;
    // ********************************************************
    // track offsets of the three copies (zero based)
    // ********************************************************
    localparam int unsigned COPY_A = 0;
    localparam int unsigned COPY_B = 6;
    localparam int unsigned COPY_C = 12;
    // ********************************************************
    // counts and reset values
    // ********************************************************
    localparam logic [1:0] GRP_CNT_RST = 2'h0;
    localparam logic [1:0] GRP_LAST = 2'h2;
    localparam logic [17:0] TAPE_RST = 18'h00000;
    localparam logic [14:0] WORD_RST = 15'h0000;
    // tape word period in ns and its cycle count at 10 MHz (floor)
    localparam int unsigned TAPE_PERIOD_NS = 78000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TAPE_PERIOD_CYC = TAPE_PERIOD_NS / CLK_PERIOD_NS;
    // ********************************************************
    // carriers
    // ********************************************************
    typedef struct packed {
        logic valid;
        logic [17:0] bits;
    } tmc_tape_type;
    typedef struct packed {
        logic valid;
        logic [14:0] bits;
    } tmc_word_type;
    typedef enum logic [1:0] {
        DEC_IDLE = 2'b00,
        DEC_VOTE = 2'b01,
        DEC_FIX = 2'b10,
        DEC_CHECK = 2'b11
    } tmc_dec_state_type;
endpackage : tmc_pkg
`default_nettype wire
